// >>> rtl/pis_slave.sv
`timescale 1ns/1ns
module pis_slave
  import pis_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_sys_rst,
  input  wire logic i_scl_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_sleep,
  output logic      o_sda_o,
  output logic      o_sda_oe,
  output pis_wr_s   o_wr
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } pis_state_e;

  pis_state_e            state;
  logic [1:0]            pin_meta;
  logic [1:0]            pin_sync;
  logic [1:0]            pin_prev;
  logic                  scl_sync;
  logic                  sda_sync;
  logic                  scl_prev;
  logic                  sda_prev;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_det;
  logic                  stop_det;
  logic                  live;
  logic [3:0]            bit_cnt;
  logic                  byte_done;
  logic [BYTE_BITS-1:0]  rx_shift;
  logic [BYTE_BITS-1:0]  tx_shift;
  logic                  dir_read;
  logic                  addr_ours;
  logic                  cmd_ok;
  logic                  wr_ok;
  logic [IDX_W-1:0]      ptr;
  logic [BYTE_BITS-1:0]  rd_data;
  logic                  sda_oe;
  logic                  hold_src;
  logic                  hold_meta;
  logic                  hold_sync;
  logic [3:0]            rec_cnt;
  logic                  rec_flag;
  logic                  rec_meta;
  logic                  rec_sync;
  logic                  rec_prev;
  logic                  rec_hit;

  // Pin synchronisers, bit 1 is SCL and bit 0 is SDA
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          pin_meta[g] <= 1'b1;
          pin_sync[g] <= 1'b1;
          pin_prev[g] <= 1'b1;
        end else begin
          pin_meta[g] <= (g == 1) ? i_scl : i_sda;
          pin_sync[g] <= pin_meta[g];
          pin_prev[g] <= pin_sync[g];
        end
      end
    end
  endgenerate

  assign scl_sync  = pin_sync[1];
  assign sda_sync  = pin_sync[0];
  assign scl_prev  = pin_prev[1];
  assign sda_prev  = pin_prev[0];
  assign scl_rise  = scl_sync & ~scl_prev;
  assign scl_fall  = ~scl_sync & scl_prev;
  assign start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_det  = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign rec_hit   = rec_sync & ~rec_prev;
  assign live      = ~i_sleep & ~rec_hit & ~start_det & ~stop_det;
  assign byte_done = (bit_cnt == BIT_DONE);
  assign addr_ours = (rx_shift == HOST_WRITE_SLAVE_ADDRESS) || (rx_shift == HOST_READ_SLAVE_ADDRESS);
  assign cmd_ok    = pis_readable(rx_shift);
  assign wr_ok     = pis_writable(ptr);

  // Protocol sequencing
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state    <= ST_IDLE;
      dir_read <= 1'b0;
    end else if (i_sleep || rec_hit) begin
      state <= ST_IDLE;
    end else if (start_det) begin
      state <= ST_ADDR;
    end else if (stop_det) begin
      state <= ST_IDLE;
    end else if (scl_fall) begin
      case (state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_ADDR: begin
          if (byte_done) begin
            state    <= addr_ours ? ST_ADDR_ACK : ST_IDLE;
            dir_read <= rx_shift[0];
          end
        end
        ST_ADDR_ACK: begin
          state <= dir_read ? ST_RDATA : ST_CMD;
        end
        ST_CMD: begin
          if (byte_done) begin
            state <= cmd_ok ? ST_CMD_ACK : ST_IDLE;
          end
        end
        ST_CMD_ACK: begin
          state <= ST_WDATA;
        end
        ST_WDATA: begin
          if (byte_done) begin
            state <= wr_ok ? ST_WDATA_ACK : ST_IDLE;
          end
        end
        ST_WDATA_ACK: begin
          state <= ST_IDLE;
        end
        ST_RDATA: begin
          if (byte_done) begin
            state <= ST_RDATA_ACK;
          end
        end
        ST_RDATA_ACK: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Bit counting and receive shifting
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bit_cnt  <= '0;
      rx_shift <= '0;
    end else if (start_det || !live) begin
      bit_cnt <= '0;
    end else if (scl_rise && !byte_done && (state == ST_ADDR || state == ST_CMD || state == ST_WDATA)) begin
      rx_shift <= {rx_shift[BYTE_BITS-2:0], sda_sync};
      bit_cnt  <= bit_cnt + 4'h1;
    end else if (scl_rise && !byte_done && state == ST_RDATA) begin
      bit_cnt <= bit_cnt + 4'h1;
    end else if (scl_fall && byte_done) begin
      bit_cnt <= '0;
    end
  end

  // Register pointer
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ptr <= '0;
    end else if (live && scl_fall && state == ST_CMD && byte_done && cmd_ok) begin
      ptr <= rx_shift[IDX_W-1:0];
    end
  end

  // Transmit shifter, loaded from the selected register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_shift <= '0;
    end else if (live && scl_fall && state == ST_ADDR_ACK) begin
      tx_shift <= {rd_data[BYTE_BITS-2:0], 1'b0};
    end else if (live && scl_fall && state == ST_RDATA && !byte_done) begin
      tx_shift <= {tx_shift[BYTE_BITS-2:0], 1'b0};
    end
  end

  // Data line drive, changes after SCL falls or on sleep, start, stop or recovery
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sda_oe <= 1'b0;
    end else if (i_sleep) begin
      sda_oe <= 1'b1;
    end else if (rec_hit || start_det || stop_det || state == ST_IDLE) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (byte_done) begin
            sda_oe <= addr_ours;
          end
        end
        ST_CMD: begin
          if (byte_done) begin
            sda_oe <= cmd_ok;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            sda_oe <= wr_ok;
          end
        end
        ST_ADDR_ACK: begin
          sda_oe <= dir_read ? ~rd_data[BYTE_BITS-1] : 1'b0;
        end
        ST_RDATA: begin
          sda_oe <= byte_done ? 1'b0 : ~tx_shift[BYTE_BITS-1];
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Output pin level is always low; SCL has no driver at all
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sda_o <= 1'b0;
    end else begin
      o_sda_o <= 1'b0;
    end
  end

  assign o_sda_oe = sda_oe;

  // Write commit at the trailing edge of the final acknowledge pulse
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wr <= '0;
    end else begin
      o_wr.vld <= live && scl_fall && (state == ST_WDATA_ACK);
      if (live && scl_fall && state == ST_WDATA_ACK) begin
        o_wr.idx  <= ptr;
        o_wr.data <= rx_shift;
      end
    end
  end

  pis_regmem #(
    .DW    (BYTE_BITS),
    .AW    (IDX_W),
    .DEPTH (REG_DEPTH)
  ) u_regmem (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_we      (o_wr.vld),
    .i_waddr   (o_wr.idx),
    .i_wdata   (o_wr.data),
    .i_raddr   (ptr),
    .o_rdata   (rd_data)
  );

  // Stuck-low recovery: count SCL pulses on the link clock while SDA is held
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold_src <= 1'b0;
    end else begin
      hold_src <= sda_oe & ~i_sleep;
    end
  end

  always_ff @(posedge i_scl_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold_meta <= 1'b0;
      hold_sync <= 1'b0;
    end else begin
      hold_meta <= hold_src;
      hold_sync <= hold_meta;
    end
  end

  always_ff @(posedge i_scl_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rec_cnt  <= '0;
      rec_flag <= 1'b0;
    end else begin
      if (!hold_sync) begin
        rec_cnt <= '0;
      end else if (rec_cnt != RECOVER_COUNT) begin
        rec_cnt <= rec_cnt + 4'h1;
      end
      rec_flag <= hold_sync && (rec_cnt >= RECOVER_LAST);
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rec_meta <= 1'b0;
      rec_sync <= 1'b0;
      rec_prev <= 1'b0;
    end else begin
      rec_meta <= rec_flag;
      rec_sync <= rec_meta;
      rec_prev <= rec_sync;
    end
  end

  AST_ACK_OWN: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    live && scl_fall && state == ST_ADDR && byte_done && addr_ours |=> state == ST_ADDR_ACK && sda_oe)
    else $error("own address not acknowledged");

  AST_NACK_FOREIGN: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    live && scl_fall && state == ST_ADDR && byte_done && !addr_ours |=> state == ST_IDLE && !sda_oe)
    else $error("foreign address acknowledged");

  AST_START_PRIO: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    start_det && !i_sleep && !rec_hit |=> state == ST_ADDR && bit_cnt == 4'h0 && !sda_oe)
    else $error("start did not restart the address phase");

  AST_STOP_IDLE: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    stop_det && !i_sleep |=> state == ST_IDLE ##1 !sda_oe)
    else $error("stop did not return to idle");

  AST_IDLE_QUIET: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    state == ST_IDLE && !start_det |=> state == ST_IDLE && $stable(ptr) && !o_wr.vld)
    else $error("idle reacted to bus activity");

  AST_PTR_FORBIDDEN: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    live && scl_fall && state == ST_CMD && byte_done && !cmd_ok |=> ptr == $past(ptr) && !sda_oe)
    else $error("forbidden index changed pointer or was acknowledged");

  AST_PTR_LOAD: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    live && scl_fall && state == ST_CMD && byte_done && cmd_ok |=> ptr == $past(rx_shift[IDX_W-1:0]) && sda_oe)
    else $error("permitted index not loaded");

  AST_COMMIT: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    live && scl_fall && state == ST_WDATA_ACK |=> o_wr.vld && o_wr.data == $past(rx_shift) && o_wr.idx == $past(ptr))
    else $error("write not committed at final acknowledge");

  AST_WR_ONLY_AT_ACK: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    o_wr.vld |-> $past(state) == ST_WDATA_ACK && $past(scl_fall) && !$past(start_det) && !$past(stop_det))
    else $error("write committed outside final acknowledge");

  AST_RO_REJECT: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    live && scl_fall && state == ST_WDATA && byte_done && !wr_ok |=> state == ST_IDLE && !sda_oe ##1 !o_wr.vld)
    else $error("read-only write not refused");

  AST_RELEASE: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    live && scl_fall && (state == ST_CMD_ACK || state == ST_WDATA_ACK || state == ST_RDATA_ACK) |=> !sda_oe)
    else $error("data line not released after acknowledge");

  AST_TX_MSB: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    live && scl_fall && state == ST_ADDR_ACK && dir_read |=> state == ST_RDATA && sda_oe == ~$past(rd_data[BYTE_BITS-1]))
    else $error("read byte does not start with selected register MSB");

  AST_SLEEP_LOW: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_sleep |=> sda_oe && state == ST_IDLE)
    else $error("data line not held low in sleep");

  AST_RECOVER: assert property (@(posedge i_scl_clk) disable iff (i_sys_rst)
    hold_sync && rec_cnt == RECOVER_LAST |=> rec_flag)
    else $error("stuck-low recovery not raised");

endmodule

// >>> rtl/pis_pkg.sv
package pis_pkg;

  localparam int                   BYTE_BITS      = 8;
  localparam int                   IDX_W          = 6;
  localparam int                   REG_DEPTH      = 64;

  localparam logic [7:0]           HOST_WRITE_SLAVE_ADDRESS = 8'h90;
  localparam logic [7:0]           HOST_READ_SLAVE_ADDRESS  = 8'h91;

  localparam logic [7:0]           LAST_MAPPED_INDEX = 8'h27;
  localparam logic [7:0]           RESV_INDEX_A      = 8'h00;
  localparam logic [7:0]           RESV_INDEX_B      = 8'h01;
  localparam logic [7:0]           RO_INDEX_A        = 8'h02;
  localparam logic [7:0]           RO_INDEX_B        = 8'h0A;
  localparam logic [7:0]           RO_INDEX_C        = 8'h1F;
  localparam logic [7:0]           RO_INDEX_D        = 8'h20;

  localparam logic [3:0]           BIT_DONE       = 4'h8;
  localparam int                   RECOVER_PULSES = 10;
  localparam int                   SYNC_STAGES    = 2;
  localparam logic [3:0]           RECOVER_COUNT  = 4'(RECOVER_PULSES - SYNC_STAGES);
  localparam logic [3:0]           RECOVER_LAST   = 4'(RECOVER_PULSES - SYNC_STAGES - 1);

  typedef struct packed {
    logic                          vld;
    logic [IDX_W-1:0]              idx;
    logic [BYTE_BITS-1:0]          data;
  } pis_wr_s;

  // Index may be selected for reading and loaded into the pointer
  function automatic logic pis_readable(input logic [7:0] idx);
    return (idx <= LAST_MAPPED_INDEX) && (idx != RESV_INDEX_A) && (idx != RESV_INDEX_B);
  endfunction

  // Index may also take a host write
  function automatic logic pis_writable(input logic [IDX_W-1:0] idx);
    logic [7:0] w;
    w = 8'(idx);
    return pis_readable(w) && (w != RO_INDEX_A) && (w != RO_INDEX_B) && (w != RO_INDEX_C) && (w != RO_INDEX_D);
  endfunction

endpackage

// >>> rtl/pis_regmem.sv
`timescale 1ns/1ns
module pis_regmem
  import pis_pkg::*;
#(
  parameter int DW    = BYTE_BITS,
  parameter int AW    = IDX_W,
  parameter int DEPTH = REG_DEPTH
) (
  input  wire logic          i_mclk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

// >>> verification/pis_host.sv
`timescale 1ns/1ns
module pis_host #(
  parameter int PH = 120
) (
  output logic      o_scl,
  output logic      o_sda_oe,
  input  wire logic i_sda
);
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  // Start from idle or repeated start: SDA falls while SCL high
  task automatic start();
    #(PH/4) o_sda_oe = 1'b0;
    #(PH*3/4) o_scl = 1'b1;
    #PH o_sda_oe = 1'b1;
    #PH o_scl = 1'b0;
  endtask

  // SCL is left high and still after a stop
  task automatic stop();
    #(PH/4) o_sda_oe = 1'b1;
    #(PH*3/4) o_scl = 1'b1;
    #PH o_sda_oe = 1'b0;
    #PH;
  endtask

  // SDA moves a quarter phase after SCL falls, never while SCL high
  task automatic bit_io(input logic b, output logic r);
    #(PH/4) o_sda_oe = ~b;
    #(PH*3/4) o_scl = 1'b1;
    #(PH/2) r = i_sda;
    #(PH/2) o_scl = 1'b0;
  endtask

  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Single byte only, always closed by not-acknowledge
  task automatic get(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
  endtask
endmodule

// >>> verification/pis_slave_tb.sv
`timescale 1ns/1ns
module pis_slave_tb;
  import pis_pkg::*;
  logic      i_mclk;
  logic      i_sys_rst;
  logic      i_sleep;
  logic      scl;
  logic      host_oe;
  logic      o_sda_o;
  logic      o_sda_oe;
  pis_wr_s   o_wr;
  pis_wr_s   wr_last;
  int        bad_count;
  int        checks;
  int        wr_seen;
  wire logic sda;

  // Open-drain SDA with pull-up
  assign sda = host_oe ? 1'b0 : (o_sda_oe ? o_sda_o : 1'b1);

  always #2 i_mclk = ~i_mclk;

  pis_slave pis_slave_i (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_scl_clk (scl),
    .i_scl     (scl),
    .i_sda     (sda),
    .i_sleep   (i_sleep),
    .o_sda_o   (o_sda_o),
    .o_sda_oe  (o_sda_oe),
    .o_wr      (o_wr)
  );

  pis_host pis_host_i (
    .o_scl    (scl),
    .o_sda_oe (host_oe),
    .i_sda    (sda)
  );

  always @(posedge i_mclk) begin
    if (o_wr.vld === 1'b1) begin
      wr_seen <= wr_seen + 1;
      wr_last <= o_wr;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic head(input logic [7:0] idx, output logic a1, output logic a2);
    pis_host_i.start();
    pis_host_i.put(HOST_WRITE_SLAVE_ADDRESS, a1);
    pis_host_i.put(idx, a2);
  endtask

  task automatic rd_ptr(output logic [7:0] d);
    logic a;
    pis_host_i.start();
    pis_host_i.put(HOST_READ_SLAVE_ADDRESS, a);
    pis_host_i.get(d);
    pis_host_i.stop();
    check({7'h0, a}, 8'h01);
  endtask

  task automatic t_write_read();
    logic [7:0] idx [3] = '{8'h03, 8'h27, 8'h21};
    logic [7:0] dat [3] = '{8'hA5, 8'h3C, 8'h81};
    logic       a1;
    logic       a2;
    logic       a3;
    logic [7:0] d;
    int         n;
    for (int k = 0; k < 3; k++) begin
      n = wr_seen;
      head(idx[k], a1, a2);
      pis_host_i.put(dat[k], a3);
      if (k == 1) begin
        pis_host_i.stop();
      end
      repeat (8) @(posedge i_mclk);
      #1;
      check({a1, a2, a3, 5'h0}, 8'hE0);
      check(8'(wr_seen - n), 8'h01);
      check({2'h0, wr_last.idx}, idx[k]);
      check(wr_last.data, dat[k]);
      head(idx[k], a1, a2);
      rd_ptr(d);
      check(d, dat[k]);
    end
  endtask

  task automatic t_refuse();
    logic [7:0] fa [4] = '{8'h92, 8'h00, 8'h20, 8'h11};
    logic [7:0] fi [4] = '{8'h00, 8'h01, 8'h28, 8'hFF};
    logic       a1;
    logic       a2;
    logic [7:0] d;
    for (int k = 0; k < 4; k++) begin
      pis_host_i.start();
      pis_host_i.put(fa[k], a1);
      pis_host_i.put(HOST_WRITE_SLAVE_ADDRESS, a2);
      pis_host_i.stop();
      check({a1, a2, 6'h0}, 8'h00);
      head(fi[k], a1, a2);
      if (k[0]) begin
        pis_host_i.stop();
      end
      check({a1, a2, 6'h0}, 8'h80);
    end
    rd_ptr(d);
    check(d, 8'h81);
  endtask

  task automatic t_readonly();
    logic [7:0] ro [4] = '{RO_INDEX_A, RO_INDEX_B, RO_INDEX_C, RO_INDEX_D};
    logic       a1;
    logic       a2;
    logic       a3;
    logic       a4;
    int         n;
    for (int k = 0; k < 4; k++) begin
      n = wr_seen;
      head(ro[k], a1, a2);
      pis_host_i.put(8'h5A, a3);
      pis_host_i.put(HOST_WRITE_SLAVE_ADDRESS, a4);
      pis_host_i.stop();
      check({a1, a2, a3, a4, 4'h0}, 8'hC0);
      check(8'(wr_seen - n), 8'h00);
    end
  endtask

  task automatic t_abort();
    logic       a1;
    logic       a2;
    logic       r;
    logic [7:0] d;
    int         n;
    head(8'h05, a1, a2);
    pis_host_i.put(8'h42, a1);
    pis_host_i.stop();
    n = wr_seen;
    for (int k = 0; k < 2; k++) begin
      head(8'h05, a1, a2);
      // Only seven data bits before the cancel
      for (int i = 7; i > 0; i--) pis_host_i.bit_io(1'b0, r);
      if (k == 1) begin
        pis_host_i.start();
      end
      pis_host_i.stop();
    end
    repeat (8) @(posedge i_mclk);
    #1;
    check(8'(wr_seen - n), 8'h00);
    head(8'h05, a1, a2);
    rd_ptr(d);
    check(d, 8'h42);
  endtask

  task automatic t_sleep();
    logic [7:0] d;
    @(posedge i_mclk);
    #1 i_sleep = 1'b1;
    repeat (3) @(posedge i_mclk);
    #1 check({7'h0, sda}, 8'h00);
    i_sleep = 1'b0;
    repeat (6) @(posedge i_mclk);
    #1 check({7'h0, sda}, 8'h01);
    rd_ptr(d);
    check(d, 8'h42);
  endtask

  // An all-zero read holds SDA low across nine SCL pulses and drives the recovery counter
  task automatic t_recover();
    logic       a1;
    logic       a2;
    logic       a3;
    logic [7:0] d;
    head(8'h06, a1, a2);
    pis_host_i.put(8'h00, a3);
    pis_host_i.stop();
    check({a1, a2, a3, 5'h0}, 8'hE0);
    rd_ptr(d);
    check(d, 8'h00);
    head(8'h06, a1, a2);
    pis_host_i.stop();
    check({a1, a2, 6'h0}, 8'hC0);
  endtask

  initial begin
    #300000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    i_mclk    = 1'b0;
    i_sys_rst = 1'b1;
    i_sleep   = 1'b0;
    bad_count = 0;
    checks    = 0;
    wr_seen   = 0;
    wr_last   = '0;
    repeat (2) @(posedge i_mclk);
    #1 i_sys_rst = 1'b0;
    repeat (4) @(posedge i_mclk);
    #1;
    t_write_read();
    t_refuse();
    t_readonly();
    t_abort();
    t_sleep();
    t_recover();
    report_and_stop();
  end
endmodule
